// *** common/ppo_consts.svh ***
// register offsets, field positions, reset values of the port pin block
// assumes a two-bit register address and eight-bit register data
`ifndef PPO_CONSTS_SVH
`define PPO_CONSTS_SVH

// register offsets on the plain register port
`define PPO_ADDR_SAMPLE 2'h0
`define PPO_ADDR_DIR    2'h1
`define PPO_ADDR_OUT    2'h2
`define PPO_ADDR_CTRL   2'h3

// fields of the control register
`define PPO_CTRL_PUOFF_BIT 0
`define PPO_CTRL_SLEEP_BIT 1

// reset values
`define PPO_DIR_RST  8'h00
`define PPO_OUT_RST  8'h00
`define PPO_CTRL_RST 8'h00

`endif

// *** common/ppo_pkg.sv ***
// types shared by the port pin block and its surroundings
// assumes one override bundle per pin, driven by the owning peripheral
package ppo_pkg;

   // override bundle presented by an alternate-function peripheral
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic drive_override_en;
      logic drive_override_val;
      logic level_override_en;
      logic level_override_val;
      logic toggle_override_en;
      logic input_gate_override_en;
      logic input_gate_override_val;
   } ppo_ovr_s;

   typedef logic [1:0] ppo_addr_t;

endpackage

// *** verilog/ppo_port.sv ***
// one general-purpose port: per-pin direction, output and sample bits,
// alternate-function overrides, sleep clamp of the digital inputs
// assumes overrides come from peripherals on the same clock, pad input
// is asynchronous, register master never waits
// clock enable low freezes every flop; the sample latch still follows
`timescale 1ns/100ps
`include "ppo_consts.svh"

module ppo_port
#(
   parameter int WIDTH = 8
)
(
   input  wire logic                       I_REF_CLK,
   input  wire logic                       I_RST_B,
   input  wire logic                       I_CE,
   input  wire ppo_pkg::ppo_addr_t         I_ADDR,
   input  wire logic [WIDTH-1:0]           I_WDATA,
   input  wire logic                       I_WR,
   input  wire logic                       I_RD,
   output logic      [WIDTH-1:0]           O_RDATA,
   input  wire logic [WIDTH-1:0]           I_PAD_IN,
   output logic      [WIDTH-1:0]           O_PAD_OUT,
   output logic      [WIDTH-1:0]           O_PAD_OE_B,
   output logic      [WIDTH-1:0]           O_PULLUP_EN,
   output logic      [WIDTH-1:0]           O_ALT_FUNC_RAW_INPUT,
   output logic      [WIDTH-1:0]           O_ANALOG_PAD_PATH,
   input  wire ppo_pkg::ppo_ovr_s [WIDTH-1:0] I_OVR,
   input  wire logic                       I_SLEEP,
   input  wire logic [WIDTH-1:0]           I_EXTINT_EN,
   input  wire logic [WIDTH-1:0]           I_EXTINT_EDGE,
   output logic      [WIDTH-1:0]           O_EXTINT_FLAG_SET,
   output logic                            O_GLOBAL_PULLUP_OFF
);

   // software state
   logic [WIDTH-1:0] pin_dir_bit;
   logic [WIDTH-1:0] pin_out_bit;
   logic [WIDTH-1:0] pin_sample_bit;
   logic [WIDTH-1:0] sync_latch;
   logic             global_pullup_off;
   logic             sleep_q;
   logic [WIDTH-1:0] rdata;
   logic [WIDTH-1:0] flag_set;

   // next values
   logic [WIDTH-1:0] next_pin_dir_bit;
   logic [WIDTH-1:0] next_pin_out_bit;
   logic [WIDTH-1:0] next_rdata;
   logic [WIDTH-1:0] next_flag_set;
   logic             next_global_pullup_off;

   // override bundle split into per-function vectors
   logic [WIDTH-1:0] pullup_override_en;
   logic [WIDTH-1:0] pullup_override_val;
   logic [WIDTH-1:0] drive_override_en;
   logic [WIDTH-1:0] drive_override_val;
   logic [WIDTH-1:0] level_override_en;
   logic [WIDTH-1:0] level_override_val;
   logic [WIDTH-1:0] toggle_override_en;
   logic [WIDTH-1:0] input_gate_override_en;
   logic [WIDTH-1:0] input_gate_override_val;

   // decoded strobes, one set for all pins of the port
   logic             dir_write_strobe;
   logic             out_write_strobe;
   logic             data_write_strobe;
   logic             ctrl_write_strobe;
   logic             dir_read_strobe;
   logic             out_read_strobe;
   logic             sample_read_strobe;
   logic             ctrl_read_strobe;

   // pin datapath
   logic [WIDTH-1:0] normal_pullup;
   logic [WIDTH-1:0] pullup_sel;
   logic [WIDTH-1:0] drive_en;
   logic [WIDTH-1:0] port_bit;
   logic [WIDTH-1:0] port_level;
   logic [WIDTH-1:0] clamp_active;
   logic [WIDTH-1:0] input_gate;
   logic [WIDTH-1:0] alt_func_raw_input;
   logic [WIDTH-1:0] ctrl_view;
   logic [WIDTH-1:0] rst_gate;
   logic             wake_edge;

   // direction and output reset images sized to the port on purpose; the header keeps 8 bits
   localparam logic [WIDTH-1:0] dir_rst  = WIDTH'(`PPO_DIR_RST);
   localparam logic [WIDTH-1:0] out_rst  = WIDTH'(`PPO_OUT_RST);
   localparam logic [7:0]       ctrl_rst = `PPO_CTRL_RST;

   // address match shared by every strobe of the port
   function automatic logic reg_hit(input logic               strobe,
                                    input ppo_pkg::ppo_addr_t addr,
                                    input ppo_pkg::ppo_addr_t want);
      return strobe && (addr == want);
   endfunction

   // override select, used for pull-up, driver, level and input gate;
   // a plain and-or per pin, so no enable can build a priority chain
   function automatic logic [WIDTH-1:0] ovr_sel(input logic [WIDTH-1:0] en,
                                                 input logic [WIDTH-1:0] val,
                                                 input logic [WIDTH-1:0] dflt);
      return (en & val) | (~en & dflt);
   endfunction

   // unpack the per-pin overrides
   // flat vectors let every per-pin equation below run on the whole port
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++)
      begin : g_ovr
         assign pullup_override_en[gi]      = I_OVR[gi].pullup_override_en;
         assign pullup_override_val[gi]     = I_OVR[gi].pullup_override_val;
         assign drive_override_en[gi]       = I_OVR[gi].drive_override_en;
         assign drive_override_val[gi]      = I_OVR[gi].drive_override_val;
         assign level_override_en[gi]       = I_OVR[gi].level_override_en;
         assign level_override_val[gi]      = I_OVR[gi].level_override_val;
         assign toggle_override_en[gi]      = I_OVR[gi].toggle_override_en;
         assign input_gate_override_en[gi]  = I_OVR[gi].input_gate_override_en;
         assign input_gate_override_val[gi] = I_OVR[gi].input_gate_override_val;
      end
   endgenerate

   // address decode; one strobe fans out to every pin of the port
   assign dir_write_strobe   = reg_hit(I_WR, I_ADDR, `PPO_ADDR_DIR);
   assign out_write_strobe   = reg_hit(I_WR, I_ADDR, `PPO_ADDR_OUT);
   assign data_write_strobe  = reg_hit(I_WR, I_ADDR, `PPO_ADDR_SAMPLE);
   assign ctrl_write_strobe  = reg_hit(I_WR, I_ADDR, `PPO_ADDR_CTRL);
   assign dir_read_strobe    = reg_hit(I_RD, I_ADDR, `PPO_ADDR_DIR);
   assign out_read_strobe    = reg_hit(I_RD, I_ADDR, `PPO_ADDR_OUT);
   assign sample_read_strobe = reg_hit(I_RD, I_ADDR, `PPO_ADDR_SAMPLE);
   assign ctrl_read_strobe   = reg_hit(I_RD, I_ADDR, `PPO_ADDR_CTRL);

   // direction register: plain write
   assign next_pin_dir_bit = dir_write_strobe ? I_WDATA : pin_dir_bit;

   // output register: a one written to the sample address toggles the bit
   // whatever the direction; a plain write wins only at its own address
   assign next_pin_out_bit = out_write_strobe  ? I_WDATA :
                             data_write_strobe ? (pin_out_bit ^ I_WDATA) :
                                                 pin_out_bit;

   // global pull-up off lives here and is handed to the other ports
   assign next_global_pullup_off = ctrl_write_strobe ?
                                   I_WDATA[`PPO_CTRL_PUOFF_BIT] :
                                   global_pullup_off;

   // control register view: pull-off bit and registered sleep state
   // sleep bit reads the registered request, the copy the wake edge uses
   always_comb
   begin
      ctrl_view                      = '0;
      ctrl_view[`PPO_CTRL_PUOFF_BIT] = global_pullup_off;
      ctrl_view[`PPO_CTRL_SLEEP_BIT] = sleep_q;
   end

   // read mux; data appear the cycle after the strobe, zero otherwise
   // zero when idle so an or-tree of several ports needs no gating
   assign next_rdata = dir_read_strobe    ? pin_dir_bit    :
                       out_read_strobe    ? pin_out_bit    :
                       sample_read_strobe ? pin_sample_bit :
                       ctrl_read_strobe   ? ctrl_view      :
                                            '0;

   // direction bits; reset leaves every pin an input
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pin_dir_bit <= dir_rst;
      end
      else if (I_CE)
      begin
         pin_dir_bit <= next_pin_dir_bit;
      end
   end

   // output bits, written directly or toggled
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pin_out_bit <= out_rst;
      end
      else if (I_CE)
      begin
         pin_out_bit <= next_pin_out_bit;
      end
   end

   // global pull-up off bit
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         global_pullup_off <= ctrl_rst[`PPO_CTRL_PUOFF_BIT];
      end
      else if (I_CE)
      begin
         global_pullup_off <= next_global_pullup_off;
      end
   end

   // read data register, zero between reads
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         rdata <= '0;
      end
      else if (I_CE)
      begin
         rdata <= next_rdata;
      end
   end

   // toggle override inverts the output bit on its way to the pad
   assign port_bit = pin_out_bit ^ toggle_override_en;

   // normal pull-up only for {dir, out, pull-off} = 0b010
   assign normal_pullup = ~pin_dir_bit & pin_out_bit &
                          {WIDTH{~global_pullup_off}};

   // override replaces all three register bits at once
   assign pullup_sel = ovr_sel(pullup_override_en, pullup_override_val,
                               normal_pullup);

   // driver enable from direction bit or drive override
   assign drive_en = ovr_sel(drive_override_en, drive_override_val,
                             pin_dir_bit);

   // level seen on the pad while the driver is on
   assign port_level = ovr_sel(level_override_en, level_override_val,
                               port_bit);

   // clamp in deep sleep unless the pin is an enabled interrupt source;
   // a floating mid-rail pad would otherwise burn current in the gate
   assign clamp_active = {WIDTH{I_SLEEP}} & ~I_EXTINT_EN;

   // input gate: chip state or input-gate override
   assign input_gate = ovr_sel(input_gate_override_en, input_gate_override_val,
                               ~clamp_active);

   // clamped input, no synchroniser on this tap; consumers must add
   // their own unless they use it as a clock
   assign alt_func_raw_input = I_PAD_IN & input_gate;

   // sync latch transparent while the clock is high, holds while low;
   // deliberately a latch so a pin change lands within half a clock to one and a half clocks
   // the clock enable does not stop it; only the flop after it freezes
   always_latch
   begin
      if (I_REF_CLK)
      begin
         sync_latch <= alt_func_raw_input;
      end
   end

   // sample register takes the latch on the rising edge
   // second synchroniser stage; nothing else reads the latch
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         pin_sample_bit <= '0;
      end
      else if (I_CE)
      begin
         pin_sample_bit <= sync_latch;
      end
   end

   // wake = falling edge of the sleep request; the clamp drops here and
   // a masked edge-sense pin sees a low-to-high change it never had;
   // the pad level at wake is used, not one stored before sleep
   assign wake_edge     = sleep_q && !I_SLEEP;
   assign next_flag_set = {WIDTH{wake_edge}} & I_PAD_IN &
                          I_EXTINT_EDGE & ~I_EXTINT_EN;

   // sleep history; the wake edge needs last cycle's request
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         sleep_q <= 1'b0;
      end
      else if (I_CE)
      begin
         sleep_q <= I_SLEEP;
      end
   end

   // one-cycle flag-set pulses toward the interrupt flags
   always_ff @(posedge I_REF_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         flag_set <= '0;
      end
      else if (I_CE)
      begin
         flag_set <= next_flag_set;
      end
   end

   // reset gate for the pad controls, works with no clock running
   assign rst_gate = {WIDTH{I_RST_B}};

   // pad control, forced safe while reset is held
   assign O_PULLUP_EN       = pullup_sel & rst_gate;
   assign O_PAD_OE_B        = ~(drive_en & rst_gate);
   assign O_PAD_OUT         = port_level;

   // straight-through taps and registered copies
   assign O_ANALOG_PAD_PATH = I_PAD_IN;
   assign O_ALT_FUNC_RAW_INPUT = alt_func_raw_input;
   assign O_EXTINT_FLAG_SET = flag_set;
   assign O_GLOBAL_PULLUP_OFF = global_pullup_off;
   assign O_RDATA           = rdata;

endmodule // ppo_port

// *** sim/ppo_port_properties.sv ***
// concurrent checks on the port pin block, top-level ports only
// assumes the clock enable is held high while these are judged
`timescale 1ns/100ps
module ppo_port_chk
#(
   parameter int WIDTH = 8
)
(
   input  wire logic                          I_REF_CLK,
   input  wire logic                          I_RST_B,
   input  wire logic [WIDTH-1:0]              I_PAD_IN,
   input  wire logic [WIDTH-1:0]              O_PAD_OUT,
   input  wire logic [WIDTH-1:0]              O_PAD_OE_B,
   input  wire logic [WIDTH-1:0]              O_PULLUP_EN,
   input  wire logic [WIDTH-1:0]              O_ALT_FUNC_RAW_INPUT,
   input  wire logic [WIDTH-1:0]              O_ANALOG_PAD_PATH,
   input  wire ppo_pkg::ppo_ovr_s [WIDTH-1:0] I_OVR,
   input  wire logic                          I_SLEEP,
   input  wire logic [WIDTH-1:0]              I_EXTINT_EN,
   input  wire logic [WIDTH-1:0]              I_EXTINT_EDGE,
   input  wire logic [WIDTH-1:0]              O_EXTINT_FLAG_SET,
   input  wire logic                          O_GLOBAL_PULLUP_OFF
);
   logic [WIDTH-1:0] pu_e, pu_v, dd_e, dd_v, lv_e, ie_e, ie_v, lv_v, wake_v;
   // bundles flattened to vectors so each check covers all pins at once
   always_comb
      for (int k = 0; k < WIDTH; k++)
      begin
         {pu_e[k], pu_v[k], dd_e[k], dd_v[k]} = I_OVR[k][8:5];
         {lv_e[k], lv_v[k]} = I_OVR[k][4:3];
         {ie_e[k], ie_v[k]} = I_OVR[k][1:0];
      end
   assign wake_v = I_PAD_IN & I_EXTINT_EDGE & ~I_EXTINT_EN;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_wake; $fell(I_SLEEP); endsequence
   sequence s_awake; !$fell(I_SLEEP); endsequence
   property p_pu_ovr; (pu_e & (O_PULLUP_EN ^ pu_v)) == '0; endproperty
   a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override lost");
   property p_oe_ovr; (dd_e & (O_PAD_OE_B ^ ~dd_v)) == '0; endproperty
   a_oe_ovr: assert property (p_oe_ovr) else $error("driver override lost");
   property p_lv_ovr; (lv_e & (O_PAD_OUT ^ lv_v)) == '0; endproperty
   a_lv_ovr: assert property (p_lv_ovr) else $error("level override lost");
   property p_gate_ovr; (ie_e & (O_ALT_FUNC_RAW_INPUT ^ (I_PAD_IN & ie_v))) == '0; endproperty
   a_gate_ovr: assert property (p_gate_ovr) else $error("input gate override lost");
   property p_clamp; I_SLEEP |-> (~ie_e & ~I_EXTINT_EN & O_ALT_FUNC_RAW_INPUT) == '0; endproperty
   a_clamp: assert property (p_clamp) else $error("sleeping input not clamped");
   property p_escape; (~ie_e & I_EXTINT_EN & (O_ALT_FUNC_RAW_INPUT ^ I_PAD_IN)) == '0; endproperty
   a_escape: assert property (p_escape) else $error("interrupt pin clamped");
   property p_pu_off; O_GLOBAL_PULLUP_OFF |-> (~pu_e & O_PULLUP_EN) == '0; endproperty
   a_pu_off: assert property (p_pu_off) else $error("pull-up on while off");
   property p_analog; O_ANALOG_PAD_PATH == I_PAD_IN; endproperty
   a_analog: assert property (p_analog) else $error("analog path differs");
   property p_wake; s_wake |=> O_EXTINT_FLAG_SET == $past(wake_v); endproperty
   a_wake: assert property (p_wake) else $error("wake flag wrong");
   property p_quiet; s_awake |=> O_EXTINT_FLAG_SET == '0; endproperty
   a_quiet: assert property (p_quiet) else $error("flag without wake");
   // reset must win even over overrides, so the default disable is set aside
   property p_rst; disable iff (1'b0) !I_RST_B |-> O_PULLUP_EN == '0 && O_PAD_OE_B == '1;
   endproperty
   a_rst: assert property (p_rst) else $error("pull-up or driver on in reset");
endmodule // ppo_port_chk
bind ppo_port ppo_port_chk #(.WIDTH(WIDTH)) u_ppo_port_chk (.I_REF_CLK, .I_RST_B, .I_PAD_IN,
   .O_PAD_OUT, .O_PAD_OE_B, .O_PULLUP_EN, .O_ALT_FUNC_RAW_INPUT, .O_ANALOG_PAD_PATH, .I_OVR,
   .I_SLEEP, .I_EXTINT_EN, .I_EXTINT_EDGE, .O_EXTINT_FLAG_SET, .O_GLOBAL_PULLUP_OFF);

// *** sim/ppo_periph_model.sv ***
// stand-in for the alternate-function peripherals of one port
// assumes the bench picks the bundles; same clock as the port
`timescale 1ns/100ps
module ppo_periph_model
(
   input  wire logic                    i_clk,
   input  wire logic                    i_rst_b,
   input  wire ppo_pkg::ppo_ovr_s [7:0] i_cfg,
   input  wire logic [7:0]              i_raw,
   output ppo_pkg::ppo_ovr_s [7:0]      o_ovr,
   output logic [7:0]                   o_sync
);
   logic [7:0] meta;
   // bundles come from peripheral state, so registered as a real one would
   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         {o_ovr, meta, o_sync} <= '0;
      else
      begin
         o_ovr <= i_cfg;
         meta <= i_raw;
         o_sync <= meta;
      end
   end
endmodule // ppo_periph_model

// *** sim/tb.sv ***
// self-checking bench for the port pin block with a peripheral model
// assumes clock enable high outside its own test; reads checked from a queue of notes
`timescale 1ns/100ps
`include "ppo_consts.svh"
module tb;
   logic                    clk, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, slp = 1'b0, rd_d, gpoff, poff;
   logic                    ce = 1'b1;
   ppo_pkg::ppo_addr_t      addr = '0;
   logic [7:0]              wdata = '0, pad = '0, exten = '0, edg = '0, eraw, dir, out, tgl, e8;
   logic [7:0]              rdata, pout, oe_b, pu, raw, flag, exp_q[$];
   ppo_pkg::ppo_ovr_s [7:0] cfg = '0, ovr;
   logic [31:0]             seed = 32'h460ce921;
   int                      err_total = 0, n_checks = 0, i;
   ppo_port u_ppo_port (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_PAD_IN(pad), .O_PAD_OUT(pout),
      .O_PAD_OE_B(oe_b), .O_PULLUP_EN(pu), .O_ALT_FUNC_RAW_INPUT(raw), .O_ANALOG_PAD_PATH(),
      .I_OVR(ovr), .I_SLEEP(slp), .I_EXTINT_EN(exten), .I_EXTINT_EDGE(edg),
      .O_EXTINT_FLAG_SET(flag), .O_GLOBAL_PULLUP_OFF(gpoff));
   ppo_periph_model u_ppo_periph_model (.i_clk(clk), .i_rst_b(rst_b), .i_cfg(cfg),
      .i_raw(raw), .o_ovr(ovr), .o_sync());
   function automatic logic [7:0] r8();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
      return seed[7:0];
   endfunction
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // one-cycle strobes; the gap cycle keeps a strobe from being set twice at one edge
   task automatic access(input logic w, input ppo_pkg::ppo_addr_t a, input logic [7:0] d);
      @(posedge clk);
      {wr, rd} <= {w, !w};
      addr <= a;
      wdata <= d;
      if (!w)
         exp_q.push_back(d);
      @(posedge clk);
      {wr, rd} <= 2'b00;
   endtask
   always @(posedge clk)
      rd_d <= rd & rst_b;
   // read data stands only in the cycle after the strobe is taken
   always @(negedge clk)
      if (rd_d && exp_q.size() > 0)
         check("read data", rdata, exp_q.pop_front());
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      err_total++;
      summarize();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         dir = r8();
         out = r8();
         poff = i[0];
         access(1'b1, `PPO_ADDR_DIR, dir);
         access(1'b1, `PPO_ADDR_OUT, out);
         access(1'b1, `PPO_ADDR_CTRL, {7'h0, poff});
         tgl = r8();
         access(1'b1, `PPO_ADDR_SAMPLE, tgl);
         out = out ^ tgl;
         pad <= r8();
         slp <= i >= 10;
         exten <= r8();
         edg <= r8();
         cfg <= (i < 4) ? '0 : {seed, seed ^ 32'h5a3c96e1, seed[15:8]};
         repeat (3) @(posedge clk);
         @(negedge clk);
         for (int k = 0; k < 8; k++)
            eraw[k] = pad[k] & (ovr[k].input_gate_override_en ? ovr[k].input_gate_override_val
               : !(slp && !exten[k]));
         check("raw input", raw, eraw);
         for (int k = 0; k < 8; k++)
            e8[k] = ovr[k].pullup_override_en ? ovr[k].pullup_override_val
               : !dir[k] && out[k] && !poff;
         check("pull-up", pu, e8);
         for (int k = 0; k < 8; k++)
            e8[k] = !(ovr[k].drive_override_en ? ovr[k].drive_override_val : dir[k]);
         check("driver enable", oe_b, e8);
         for (int k = 0; k < 8; k++)
            e8[k] = ovr[k].level_override_en ? ovr[k].level_override_val
               : out[k] ^ ovr[k].toggle_override_en;
         check("pad level", pout, e8);
         check("pull-up off copy", {7'h0, gpoff}, {7'h0, poff});
         access(1'b0, `PPO_ADDR_SAMPLE, eraw);
         access(1'b0, `PPO_ADDR_DIR, dir);
         access(1'b0, `PPO_ADDR_OUT, out);
         access(1'b0, `PPO_ADDR_CTRL, {6'h0, slp, poff});
         @(posedge clk);
         slp <= 1'b0;
         @(posedge clk);
         @(negedge clk);
         check("wake flag", flag, slp ? 8'h00 : (i >= 10 ? pad & edg & ~exten : 8'h00));
         @(negedge clk);
         check("wake flag end", flag, 8'h00);
      end
      $display("test registers, overrides and sleep done");
      access(1'b1, `PPO_ADDR_DIR, 8'h00);
      access(1'b1, `PPO_ADDR_OUT, 8'hff);
      access(1'b1, `PPO_ADDR_CTRL, 8'h00);
      cfg <= '0;
      repeat (2) @(negedge clk);
      check("pull-up on", pu, 8'hff);
      @(posedge clk);
      ce <= 1'b0;
      access(1'b1, `PPO_ADDR_DIR, 8'hff);
      ce <= 1'b1;
      @(negedge clk);
      check("frozen pull-up", pu, 8'hff);
      check("frozen driver", oe_b, 8'hff);
      @(posedge clk);
      rst_b <= 1'b0;
      #1;
      check("reset pull-up", pu, 8'h00);
      check("reset driver", oe_b, 8'hff);
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      check("pull-up after reset", pu, 8'h00);
      access(1'b0, `PPO_ADDR_OUT, 8'h00);
      repeat (2) @(negedge clk);
      $display("test clock enable and reset done");
      summarize();
   end
endmodule // tb
